//--- hw/auart_defines.vh
/*
 * constants for the asynchronous receiver/transmitter: register offsets,
 * field positions, mode codes, divisor table and rate factors.
 * assumes inclusion by bare name from the design file.
 */
`ifndef AUART_DEFINES_VH
`define AUART_DEFINES_VH

// register offsets on the 3-bit address port
`define AU_ADDR_MODE 3'h0
`define AU_ADDR_BAUD 3'h1
`define AU_ADDR_STATUS 3'h2
`define AU_ADDR_DATA 3'h3
`define AU_ADDR_CTRL 3'h4
`define AU_ADDR_CLRERR 3'h5

// control register bits
`define AU_CTRL_RXEN 0
`define AU_CTRL_TXEN 1
`define AU_CTRL_BRK 2

// comm_mode fields
`define AU_M_LEN_HI 1
`define AU_M_LEN_LO 0
`define AU_M_STOP 2
`define AU_M_PAR_LO 3
`define AU_M_PAR_HI 4
`define AU_M_ODD 5
`define AU_M_OP_LO 6
`define AU_M_OP_HI 7
// index of the last data bit for the shortest length code
`define AU_LEN_MIN_IDX 3'h4

// operating modes
`define AU_OP_NORMAL 2'h0
`define AU_OP_ECHO 2'h1
`define AU_OP_LOCAL 2'h2
`define AU_OP_REMOTE 2'h3

// parity format codes
`define AU_PAR_NONE 2'h0
`define AU_PAR_FORCE 2'h1

// baud_clock_control fields
`define AU_B_TXINT 7
`define AU_B_RXINT 6
`define AU_B_FAC_HI 5
`define AU_B_FAC_LO 4
`define AU_B_SEL_HI 3

// comm_status bits
`define AU_S_RECEIVER_READY_FLAG 0
`define AU_S_TRANSMITTER_READY_FLAG 1
`define AU_S_TRANSMITTER_EMPTY_FLAG 2
`define AU_S_TXBRK 3
`define AU_S_RXBRK 4
`define AU_S_OVR 5
`define AU_S_FE 6
`define AU_S_PE 7

// reset value of every register
`define AU_RST_BYTE 8'h00

// divisors of the reference clock, giving the 16x clock
`define AU_DIV_0 13'h1800
`define AU_DIV_1 13'h0AE9
`define AU_DIV_2 13'h08EC
`define AU_DIV_3 13'h0800
`define AU_DIV_4 13'h0600
`define AU_DIV_5 13'h0400
`define AU_DIV_6 13'h0200
`define AU_DIV_7 13'h0124
`define AU_DIV_8 13'h0100
`define AU_DIV_9 13'h00AB
`define AU_DIV_A 13'h009A
`define AU_DIV_B 13'h0080
`define AU_DIV_C 13'h0040
`define AU_DIV_D 13'h0020
`define AU_DIV_E 13'h0010
`define AU_DIV_F 13'h0008

// clock rate factors in ticks per bit
`define AU_FAC_16 7'h10
`define AU_FAC_32 7'h20
`define AU_FAC_64 7'h40
`define AU_FAC_1 7'h01

`endif

//--- hw/auart_top.v
/*
 * asynchronous receiver/transmitter with baud divider, four operating
 * modes and a byte-wide register port.
 * assumes ref_clk_i is the reference baud clock and that the serial
 * line and both external clock pins are asynchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "auart_defines.vh"

module auart_top (
   // clock and reset
   input wire ref_clk_i,
   input wire reset_i,
   // register port
   input wire [2:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // serial line and external clocks
   input wire rx_data_i,
   input wire transmit_clock_pin_i,
   input wire receive_clock_pin_i,
   output reg tx_data_o
);

   // receiver states
   localparam [5:0] RX_IDLE = 6'h01;
   localparam [5:0] RX_START = 6'h02;
   localparam [5:0] RX_DATA = 6'h04;
   localparam [5:0] RX_PAR = 6'h08;
   localparam [5:0] RX_STOP = 6'h10;
   localparam [5:0] RX_BRKW = 6'h20;
   // transmitter states
   localparam [4:0] TX_IDLE = 5'h01;
   localparam [4:0] TX_START = 5'h02;
   localparam [4:0] TX_DATA = 5'h04;
   localparam [4:0] TX_PAR = 5'h08;
   localparam [4:0] TX_STOP = 5'h10;

   // address match for one strobe
   function hit;
      input [2:0] a;
      input [2:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // divisor for a baud select code
   function [12:0] divisor;
      input [3:0] sel;
      begin
         case (sel)
            4'h0: divisor = `AU_DIV_0;
            4'h1: divisor = `AU_DIV_1;
            4'h2: divisor = `AU_DIV_2;
            4'h3: divisor = `AU_DIV_3;
            4'h4: divisor = `AU_DIV_4;
            4'h5: divisor = `AU_DIV_5;
            4'h6: divisor = `AU_DIV_6;
            4'h7: divisor = `AU_DIV_7;
            4'h8: divisor = `AU_DIV_8;
            4'h9: divisor = `AU_DIV_9;
            4'hA: divisor = `AU_DIV_A;
            4'hB: divisor = `AU_DIV_B;
            4'hC: divisor = `AU_DIV_C;
            4'hD: divisor = `AU_DIV_D;
            4'hE: divisor = `AU_DIV_E;
            default: divisor = `AU_DIV_F;
         endcase
      end
   endfunction

   // ticks per bit for one clock source
   function [6:0] factor;
      input internal;
      input [1:0] fsel;
      begin
         if (internal) begin
            factor = `AU_FAC_16;
         end else begin
            case (fsel)
               2'h0: factor = `AU_FAC_16;
               2'h1: factor = `AU_FAC_32;
               2'h2: factor = `AU_FAC_64;
               default: factor = `AU_FAC_1;
            endcase
         end
      end
   endfunction

   // true on the last data bit of the programmed length
   function last_bit;
      input [2:0] idx;
      input [1:0] len;
      begin
         last_bit = (idx == `AU_LEN_MIN_IDX + {1'b0, len});
      end
   endfunction

   // keeps only the programmed number of data bits
   function [7:0] len_mask;
      input [1:0] len;
      begin
         len_mask = 8'hFF >> (2'h3 - len);
      end
   endfunction

   // software registers and flags
   reg [7:0] comm_mode;
   reg [7:0] baud_clock_control;
   reg [7:0] ctrl;
   reg [7:0] receive_holding_register;
   reg receiver_ready_flag;
   reg rx_break_flag;
   reg overrun_flag;
   reg framing_flag;
   reg parity_flag;
   reg [7:0] transmit_holding_register;
   reg tx_hold_par;
   reg tx_hold_raw;
   reg tx_hold_full;
   reg transmitter_empty_flag;

   // synchronisers and edge history
   reg [2:0] rxd_sync;
   reg [2:0] txc_sync;
   reg [2:0] rxc_sync;

   // decoded mode
   wire [1:0] op_mode = comm_mode[`AU_M_OP_HI:`AU_M_OP_LO];
   wire [1:0] char_len = comm_mode[`AU_M_LEN_HI:`AU_M_LEN_LO];
   wire [1:0] par_fmt = comm_mode[`AU_M_PAR_HI:`AU_M_PAR_LO];
   wire par_on = (par_fmt != `AU_PAR_NONE);
   wire echo_like = (op_mode == `AU_OP_ECHO) || (op_mode == `AU_OP_REMOTE);
   wire local_loop = (op_mode == `AU_OP_LOCAL);
   wire rx_en = ctrl[`AU_CTRL_RXEN];
   wire tx_en = ctrl[`AU_CTRL_TXEN];
   wire tx_brk = ctrl[`AU_CTRL_BRK];
   wire tx_run = tx_en || echo_like;
   wire wr_data = wr_i && hit(addr_i, `AU_ADDR_DATA);
   wire rd_data = rd_i && hit(addr_i, `AU_ADDR_DATA);
   wire clr_err = wr_i && hit(addr_i, `AU_ADDR_CLRERR);

   // two-flop synchronisers, third flop only for edge detection
   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         rxd_sync <= 3'h7;
         txc_sync <= 3'h0;
         rxc_sync <= 3'h0;
      end else begin
         rxd_sync <= {rxd_sync[1:0], rx_data_i};
         txc_sync <= {txc_sync[1:0], transmit_clock_pin_i};
         rxc_sync <= {rxc_sync[1:0], receive_clock_pin_i};
      end
   end

   // baud divider producing the internal 16x tick
   reg [12:0] div_cnt;
   reg int_tick;
   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         div_cnt <= 13'h0000;
         int_tick <= 1'b0;
      end else if (div_cnt >= divisor(baud_clock_control[`AU_B_SEL_HI:0]) - 13'h0001) begin
         div_cnt <= 13'h0000;
         int_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 13'h0001;
         int_tick <= 1'b0;
      end
   end

   // clock source selection per direction
   wire ext_tx_tick = txc_sync[1] && !txc_sync[2];
   wire ext_rx_tick = rxc_sync[1] && !rxc_sync[2];
   wire [1:0] fsel = baud_clock_control[`AU_B_FAC_HI:`AU_B_FAC_LO];
   wire own_tx_tick = baud_clock_control[`AU_B_TXINT] ? int_tick : ext_tx_tick;
   wire own_rx_tick = baud_clock_control[`AU_B_RXINT] ? int_tick : ext_rx_tick;
   wire [6:0] own_tx_fac = factor(baud_clock_control[`AU_B_TXINT], fsel);
   wire [6:0] own_rx_fac = factor(baud_clock_control[`AU_B_RXINT], fsel);
   // echo modes run the transmitter on the receive clock, local loop the reverse
   wire tx_tick = echo_like ? own_rx_tick : own_tx_tick;
   wire [6:0] tx_fac = echo_like ? own_rx_fac : own_tx_fac;
   wire rx_tick = local_loop ? own_tx_tick : own_rx_tick;
   wire [6:0] rx_fac = local_loop ? own_tx_fac : own_rx_fac;
   wire [6:0] rx_half = rx_fac >> 1;

   // internal serial bit of the transmitter, fed back in local loop
   reg tx_bit;
   wire rx_line = local_loop ? tx_bit : rxd_sync[1];
   reg rx_prev;

   // receiver
   reg [5:0] rx_state;
   reg [6:0] rx_cnt;
   reg [2:0] rx_idx;
   reg [7:0] receive_shift_register;
   reg rx_par_bit;
   reg rx_load;
   reg [7:0] rx_echo_data;
   reg rx_echo_par;
   wire [7:0] rx_char = (receive_shift_register >> (2'h3 - char_len)) & len_mask(char_len);
   wire rx_par_good = (^rx_char) ^ rx_par_bit ^ comm_mode[`AU_M_ODD];
   wire rx_par_err = (par_fmt == `AU_PAR_FORCE) ? (rx_par_bit != comm_mode[`AU_M_ODD])
                                                : !rx_par_good;
   wire rx_is_break = !rx_line && (rx_char == 8'h00) && !(par_on && rx_par_bit);
   wire rx_bit_end = rx_tick && (rx_cnt >= rx_fac - 7'h01);

   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         rx_state <= RX_IDLE;
         rx_cnt <= 7'h00;
         rx_idx <= 3'h0;
         rx_prev <= 1'b1;
         receive_shift_register <= `AU_RST_BYTE;
         rx_par_bit <= 1'b0;
         rx_load <= 1'b0;
         rx_echo_data <= `AU_RST_BYTE;
         rx_echo_par <= 1'b0;
         receive_holding_register <= `AU_RST_BYTE;
         receiver_ready_flag <= 1'b0;
         rx_break_flag <= 1'b0;
         overrun_flag <= 1'b0;
         framing_flag <= 1'b0;
         parity_flag <= 1'b0;
      end else begin
         rx_prev <= rx_line;
         rx_load <= 1'b0;
         // clears first, so a set in the same cycle wins
         if (rd_data) begin
            receiver_ready_flag <= 1'b0;
         end
         if (clr_err || !rx_en) begin
            overrun_flag <= 1'b0;
            framing_flag <= 1'b0;
            parity_flag <= 1'b0;
         end
         if (!rx_en) begin
            receiver_ready_flag <= 1'b0;
            rx_break_flag <= 1'b0;
         end
         if (rx_tick && rx_state != RX_BRKW) begin
            rx_cnt <= rx_cnt + 7'h01;
         end
         case (rx_state)
            RX_IDLE: begin
               rx_cnt <= 7'h00;
               if (rx_en && rx_prev && !rx_line) begin
                  rx_state <= RX_START;
               end
            end
            RX_START: begin
               if (!rx_en) begin
                  rx_state <= RX_IDLE;
               end else if (rx_tick && ({1'b0, rx_cnt} + 8'h01 >= {1'b0, rx_half})) begin
                  rx_cnt <= 7'h00;
                  rx_idx <= 3'h0;
                  rx_state <= rx_line ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_bit_end) begin
                  rx_cnt <= 7'h00;
                  receive_shift_register <= {rx_line, receive_shift_register[7:1]};
                  rx_idx <= rx_idx + 3'h1;
                  if (last_bit(rx_idx, char_len)) begin
                     rx_state <= par_on ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR: begin
               if (rx_bit_end) begin
                  rx_cnt <= 7'h00;
                  rx_par_bit <= rx_line;
                  rx_state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_bit_end) begin
                  rx_cnt <= 7'h00;
                  rx_load <= 1'b1;
                  rx_echo_data <= rx_char;
                  rx_echo_par <= par_on ? rx_par_bit : 1'b0;
                  // error flags of this character load together
                  if (par_on && rx_par_err) begin
                     parity_flag <= 1'b1;
                  end
                  if (!rx_line) begin
                     framing_flag <= 1'b1;
                  end
                  if (op_mode != `AU_OP_REMOTE) begin
                     receive_holding_register <= rx_char;
                     if (receiver_ready_flag && !rd_data) begin
                        overrun_flag <= 1'b1;
                     end
                     if (!rx_is_break) begin
                        receiver_ready_flag <= 1'b1;
                     end
                  end
                  if (rx_is_break) begin
                     rx_break_flag <= 1'b1;
                     rx_state <= RX_BRKW;
                  end else if (!rx_line && rx_char != 8'h00) begin
                     rx_state <= RX_START;
                  end else begin
                     rx_state <= RX_IDLE;
                  end
               end
            end
            RX_BRKW: begin
               // line must stay high for a whole bit before hunting again
               if (!rx_line || !rx_en) begin
                  rx_cnt <= 7'h00;
                  if (!rx_en) begin
                     rx_state <= RX_IDLE;
                  end
               end else if (rx_tick) begin
                  if (rx_cnt >= rx_fac - 7'h01) begin
                     rx_break_flag <= 1'b0;
                     rx_state <= RX_IDLE;
                  end else begin
                     rx_cnt <= rx_cnt + 7'h01;
                  end
               end
            end
            default: begin
               rx_state <= RX_IDLE;
            end
         endcase
      end
   end

   // transmitter
   reg [4:0] tx_state;
   reg [6:0] tx_cnt;
   reg [2:0] tx_idx;
   reg [7:0] transmit_shift_register;
   reg tx_par_val;
   reg tx_stop2;
   reg tx_sent_one;
   wire tx_bit_end = tx_tick && (tx_cnt >= tx_fac - 7'h01);
   wire [7:0] tx_masked = transmit_holding_register & len_mask(char_len);
   wire tx_calc_par = (par_fmt == `AU_PAR_FORCE) ? comm_mode[`AU_M_ODD]
                                                 : (^tx_masked) ^ ~comm_mode[`AU_M_ODD];

   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         tx_state <= TX_IDLE;
         tx_cnt <= 7'h00;
         tx_idx <= 3'h0;
         tx_bit <= 1'b1;
         transmit_shift_register <= `AU_RST_BYTE;
         tx_par_val <= 1'b0;
         tx_stop2 <= 1'b0;
         tx_sent_one <= 1'b0;
         transmit_holding_register <= `AU_RST_BYTE;
         tx_hold_par <= 1'b0;
         tx_hold_raw <= 1'b0;
         tx_hold_full <= 1'b0;
         transmitter_empty_flag <= 1'b0;
      end else begin
         if (!tx_run) begin
            transmitter_empty_flag <= 1'b0;
         end
         // holding register load: receiver in echo modes, cpu otherwise
         if (echo_like && rx_load) begin
            transmit_holding_register <= rx_echo_data;
            tx_hold_par <= rx_echo_par;
            tx_hold_raw <= 1'b1;
            tx_hold_full <= 1'b1;
            transmitter_empty_flag <= 1'b0;
         end else if (!echo_like && wr_data) begin
            transmit_holding_register <= wdata_i;
            tx_hold_raw <= 1'b0;
            tx_hold_full <= 1'b1;
            transmitter_empty_flag <= 1'b0;
         end
         if (tx_tick && tx_state != TX_IDLE) begin
            tx_cnt <= tx_cnt + 7'h01;
         end
         case (tx_state)
            TX_IDLE: begin
               tx_cnt <= 7'h00;
               tx_bit <= 1'b1;
               if (tx_hold_full && tx_run && tx_tick) begin
                  transmit_shift_register <= tx_masked;
                  tx_par_val <= tx_hold_raw ? tx_hold_par : tx_calc_par;
                  tx_hold_full <= (echo_like && rx_load) || (!echo_like && wr_data);
                  tx_bit <= 1'b0;
                  tx_state <= TX_START;
               end
            end
            TX_START: begin
               if (tx_bit_end) begin
                  tx_cnt <= 7'h00;
                  tx_idx <= 3'h0;
                  tx_bit <= transmit_shift_register[0];
                  transmit_shift_register <= transmit_shift_register >> 1;
                  tx_state <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_bit_end) begin
                  tx_cnt <= 7'h00;
                  tx_idx <= tx_idx + 3'h1;
                  if (last_bit(tx_idx, char_len)) begin
                     tx_bit <= par_on ? tx_par_val : 1'b1;
                     tx_stop2 <= comm_mode[`AU_M_STOP];
                     tx_state <= par_on ? TX_PAR : TX_STOP;
                  end else begin
                     tx_bit <= transmit_shift_register[0];
                     transmit_shift_register <= transmit_shift_register >> 1;
                  end
               end
            end
            TX_PAR: begin
               if (tx_bit_end) begin
                  tx_cnt <= 7'h00;
                  tx_bit <= 1'b1;
                  tx_stop2 <= comm_mode[`AU_M_STOP];
                  tx_state <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (tx_bit_end) begin
                  tx_cnt <= 7'h00;
                  if (tx_stop2) begin
                     tx_stop2 <= 1'b0;
                  end else begin
                     tx_sent_one <= 1'b1;
                     tx_state <= TX_IDLE;
                     if (!tx_hold_full && tx_run) begin
                        transmitter_empty_flag <= 1'b1;
                     end
                  end
               end
            end
            default: begin
               tx_state <= TX_IDLE;
            end
         endcase
      end
   end

   // serial output: break low, held high in local loop
   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         tx_data_o <= 1'b1;
      end else if (tx_brk) begin
         tx_data_o <= 1'b0;
      end else if (local_loop) begin
         tx_data_o <= 1'b1;
      end else begin
         tx_data_o <= tx_bit;
      end
   end

   // register writes
   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         comm_mode <= `AU_RST_BYTE;
         baud_clock_control <= `AU_RST_BYTE;
         ctrl <= `AU_RST_BYTE;
      end else if (wr_i) begin
         if (hit(addr_i, `AU_ADDR_MODE)) begin
            comm_mode <= wdata_i;
         end
         if (hit(addr_i, `AU_ADDR_BAUD)) begin
            baud_clock_control <= wdata_i;
         end
         if (hit(addr_i, `AU_ADDR_CTRL)) begin
            ctrl <= wdata_i & 8'h07;
         end
      end
   end

   // status byte and registered read data
   wire [7:0] status;
   assign status[`AU_S_RECEIVER_READY_FLAG] = receiver_ready_flag;
   assign status[`AU_S_TRANSMITTER_READY_FLAG] = tx_en && !echo_like && !tx_hold_full;
   assign status[`AU_S_TRANSMITTER_EMPTY_FLAG] = transmitter_empty_flag && tx_sent_one;
   assign status[`AU_S_TXBRK] = tx_brk;
   assign status[`AU_S_RXBRK] = rx_break_flag;
   assign status[`AU_S_OVR] = overrun_flag;
   assign status[`AU_S_FE] = framing_flag;
   assign status[`AU_S_PE] = parity_flag;

   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         rdata_o <= `AU_RST_BYTE;
      end else if (rd_i) begin
         case (addr_i)
            `AU_ADDR_MODE: rdata_o <= comm_mode;
            `AU_ADDR_BAUD: rdata_o <= baud_clock_control;
            `AU_ADDR_STATUS: rdata_o <= status;
            `AU_ADDR_DATA: rdata_o <= receive_holding_register;
            `AU_ADDR_CTRL: rdata_o <= ctrl;
            default: rdata_o <= `AU_RST_BYTE;
         endcase
      end else begin
         rdata_o <= `AU_RST_BYTE;
      end
   end

endmodule
`default_nettype wire

//--- bench/auart_top_props.sv
/* checker for the serial block: register port and serial output.
   bound to auart_top from the bench top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module auart_top_props (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // register port
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // serial output
   input wire logic tx_data_o
);
   logic [7:0] mode_q;
   logic [7:0] baud_q;
   logic brk_q;
   logic dirty_q;
   logic loc_q;
   logic [6:0] run_q;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // shadows of mode, baud and break writes; break edges mark the line dirty
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         mode_q <= 8'h00;
         baud_q <= 8'h00;
         brk_q <= 1'b0;
         dirty_q <= 1'b0;
      end else begin
         if (wr_i && addr_i == 3'h0) mode_q <= wdata_i;
         if (wr_i && addr_i == 3'h1) baud_q <= wdata_i;
         if (wr_i && addr_i == 3'h4) brk_q <= wdata_i[2];
         if (wr_i && addr_i == 3'h4 && wdata_i[2]) dirty_q <= 1'b1;
         else if ($rose(tx_data_o) && !brk_q) dirty_q <= 1'b0;
      end
   end
   // cycles since the output last changed; local loop seen one cycle late
   always_ff @(posedge ref_clk_i) begin
      loc_q <= (mode_q[7:6] == 2'h2);
      run_q <= $changed(tx_data_o) ? 7'h00 : run_q + 7'h01;
   end
   chk_reset_idle: assert property (disable iff (1'b0) reset_i |=> tx_data_o)
      else $error("output not idle high after reset");
   chk_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   chk_len_upper: assert property (rd_i && addr_i == 3'h3 |=>
      (rdata_o >> (mode_q[1:0] + 4'h5)) == 8'h00) else $error("unused data bits set");
   chk_rdy_clear: assert property (rd_i && addr_i == 3'h3 ##2 rd_i && addr_i == 3'h2
      |=> !rdata_o[0]) else $error("ready still set after data read");
   chk_err_clear: assert property (wr_i && addr_i == 3'h5 ##2 rd_i && addr_i == 3'h2
      |=> rdata_o[7:5] == 3'h0) else $error("error flags survive clear");
   chk_brk_low: assert property (wr_i && addr_i == 3'h4 && wdata_i[2]
      |-> ##[1:4] !tx_data_o) else $error("break did not drive line low");
   chk_bit_width: assert property ($rose(tx_data_o) && !dirty_q && baud_q[7]
      && baud_q[3:0] == 4'hF |-> run_q == 7'h7F) else $error("low run not whole bits");
   chk_loop_high: assert property (loc_q && $past(loc_q) |-> tx_data_o)
      else $error("output not high in local loop");
   cover property (rd_i && addr_i == 3'h3);
   cover property ($rose(tx_data_o) && !dirty_q && baud_q[7]);
   cover property (loc_q && rd_i);
endmodule
`default_nettype wire

//--- bench/auart_line_model.sv
/* far-side serial terminal: sends frames on the receive line and
   captures frames from the transmit line, 128 reference cycles a bit. */
`timescale 1ns/1ps
`default_nettype none
module auart_line_model (
   // clock
   input wire logic clk_i,
   // serial lines
   input wire logic tx_line_i,
   output logic rx_line_o
);
   localparam int BIT = 128;
   int nb = 8;
   int cnt = 0;
   logic [8:0] got;
   logic [8:0] sh;
   initial rx_line_o = 1'b1;
   // one bit cell on the receive line
   task automatic bit_out(input logic b);
      @(posedge clk_i);
      rx_line_o <= b;
      repeat (BIT - 1) @(posedge clk_i);
   endtask
   // frame: start, data lsb first, one stop, then idle high
   task automatic send(input logic [7:0] d, input int n, input logic stop);
      bit_out(1'b0);
      for (int i = 0; i < n; i++) bit_out(d[i]);
      bit_out(stop);
      bit_out(1'b1);
   endtask
   // capture: half-bit start check, then bit centres
   always begin
      @(negedge tx_line_i);
      repeat (BIT / 2) @(posedge clk_i);
      if (!tx_line_i) begin
         sh = 9'h000;
         for (int i = 0; i < nb; i++) begin
            repeat (BIT) @(posedge clk_i);
            sh[i] = tx_line_i;
         end
         got = sh;
         cnt++;
         repeat (BIT) @(posedge clk_i);
      end
   end
endmodule
`default_nettype wire

//--- bench/auart_top_tb_top.sv
/* testbench top: register tasks, line partner, checker bind.
   assumes divisor code F so one bit is 128 reference cycles. */
`timescale 1ns/1ps
`default_nettype none
module auart_top_tb_top;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic rx_data_i;
   logic tx_data_o;
   int miscompares = 0;
   int num_checks = 0;
   int c;
   logic [7:0] tmode [3] = '{8'h03, 8'h1B, 8'h0B};
   logic [8:0] texp [3] = '{9'h0A5, 9'h1A5, 9'h0A5};
   int tnb [3] = '{8, 9, 9};
   always #2.5 ref_clk_i = ~ref_clk_i;
   auart_top auart_top_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_data_i(rx_data_i),
      .transmit_clock_pin_i(1'b0), .receive_clock_pin_i(1'b0), .tx_data_o(tx_data_o));
   auart_line_model auart_line_model_i (.clk_i(ref_clk_i), .tx_line_i(tx_data_o),
      .rx_line_o(rx_data_i));
   // compare and count
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   // read, mask and compare the data of the following cycle
   task automatic rdc(input string what, input logic [2:0] a, input logic [7:0] m,
      input logic [7:0] e);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 check(what, {1'b0, rdata_o & m}, {1'b0, e});
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rdc("mode", 3'h0, 8'hFF, 8'h00);
      rdc("baud", 3'h1, 8'hFF, 8'h00);
      rdc("status", 3'h2, 8'hFF, 8'h00);
      rdc("unmapped", 3'h6, 8'hFF, 8'h00);
      wr(3'h1, 8'hCF);
      wr(3'h4, 8'h03);
      for (int k = 0; k < 3; k++) begin
         wr(3'h0, tmode[k]);
         auart_line_model_i.nb = tnb[k];
         c = auart_line_model_i.cnt;
         wr(3'h3, 8'hA5);
         for (int j = 0; j < 3000 && auart_line_model_i.cnt == c; j++) @(posedge ref_clk_i);
         check("tx frame", auart_line_model_i.got, texp[k]);
         repeat (500) @(posedge ref_clk_i);
      end
      rdc("tx empty", 3'h2, 8'h06, 8'h06);
      wr(3'h0, 8'h03);
      auart_line_model_i.send(8'h3C, 8, 1'b1);
      rdc("rx ready", 3'h2, 8'h01, 8'h01);
      rdc("rx data", 3'h3, 8'hFF, 8'h3C);
      rdc("rx ready clear", 3'h2, 8'h01, 8'h00);
      wr(3'h0, 8'h00);
      auart_line_model_i.send(8'hF5, 5, 1'b1);
      rdc("short data", 3'h3, 8'hFF, 8'h15);
      wr(3'h0, 8'h1A);
      auart_line_model_i.send(8'h83, 8, 1'b1);
      rdc("parity ok", 3'h2, 8'h80, 8'h00);
      rdc("par data", 3'h3, 8'hFF, 8'h03);
      auart_line_model_i.send(8'h03, 8, 1'b1);
      rdc("parity error", 3'h2, 8'h80, 8'h80);
      wr(3'h0, 8'h03);
      auart_line_model_i.send(8'h11, 8, 1'b1);
      auart_line_model_i.send(8'h22, 8, 1'b0);
      repeat (2600) @(posedge ref_clk_i);
      rdc("errors", 3'h2, 8'h60, 8'h60);
      wr(3'h5, 8'h00);
      rdc("errors clear", 3'h2, 8'hE0, 8'h00);
      wr(3'h4, 8'h07);
      repeat (5) @(posedge ref_clk_i);
      #1 check("break line", {8'h00, tx_data_o}, 9'h000);
      rdc("break status", 3'h2, 8'h08, 8'h08);
      wr(3'h4, 8'h03);
      repeat (300) @(posedge ref_clk_i);
      wr(3'h4, 8'h00);
      wr(3'h0, 8'h43);
      wr(3'h4, 8'h03);
      auart_line_model_i.nb = 8;
      auart_line_model_i.send(8'h96, 8, 1'b1);
      c = auart_line_model_i.cnt;
      for (int j = 0; j < 3000 && auart_line_model_i.cnt == c; j++) @(posedge ref_clk_i);
      check("echo frame", auart_line_model_i.got, 9'h096);
      rdc("echo status", 3'h2, 8'h03, 8'h01);
      rdc("echo data", 3'h3, 8'hFF, 8'h96);
      wr(3'h4, 8'h00);
      wr(3'h0, 8'h83);
      wr(3'h4, 8'h03);
      wr(3'h3, 8'h5A);
      repeat (1500) @(posedge ref_clk_i);
      rdc("loop data", 3'h3, 8'hFF, 8'h5A);
      wrap_up;
   end
   // watchdog well beyond the expected run
   initial begin
      #400000;
      miscompares++;
      wrap_up;
   end
endmodule
bind auart_top auart_top_props auart_top_props_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .tx_data_o(tx_data_o));
`default_nettype wire
